// *** logic/ccd_head_pkg.sv ***
package ccd_head_pkg;

    // Clock rates and derived divider
    localparam int unsigned CLK_PERIOD_NS    = 25;
    localparam int unsigned MASTER_PERIOD_NS = 100;
    localparam int unsigned TICK_DIV         = (MASTER_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned DIV_W            = 2;
    localparam logic [DIV_W-1:0] DIV_LAST    = DIV_W'(TICK_DIV - 1);
    localparam logic [DIV_W-1:0] DIV_RESET   = 2'h0;

    // Row transfer timing in master clock periods
    localparam int unsigned ROW_PERIODS      = 6;
    localparam int unsigned PHASE_W          = 3;
    localparam logic [PHASE_W-1:0] PHASE_LAST  = PHASE_W'(ROW_PERIODS - 1);
    localparam logic [PHASE_W-1:0] PHASE_RESET = 3'h0;

    // Widths
    localparam int unsigned PIXEL_W          = 9;
    localparam int unsigned ROW_CNT_W        = 9;
    localparam logic [ROW_CNT_W-1:0] ROWS_RESET = 9'h000;
    localparam logic [ROW_CNT_W-1:0] ROW_ONE    = 9'h001;
    localparam logic [PIXEL_W-1:0]   PIXEL_RESET = 9'h000;

    // Inactive level of the active-low head controls
    localparam logic RUN_IDLE = 1'b1;

    typedef enum logic [1:0] {
        V_IDLE = 2'b01,
        V_RUN  = 2'b10
    } vstate_t;

endpackage : ccd_head_pkg

// *** logic/ccd_head_sequencer_interface.sv ***
`timescale 1ns/10ps
// Summary of operation
// - All logic on one clock, rising edge; the tick divider and pixel synchronisers update every 25ns clock.
// - Head controls are active low and change only on master clock edges.
// - storage_run_n low pulses last a whole multiple of 6 periods.
// - image_run_n is never low unless storage_run_n is low too.
// - camera_reset_n is low while the camera is held in reset.
// - Pixel word is captured in a register on the master clock.
module ccd_head_sequencer_interface
    import ccd_head_pkg::*;
(
    input  wire logic                 CLK,
    input  wire logic                 RESET_N,
    input  wire logic                 HORIZONTAL_ENABLE,
    input  wire logic                 ROW_START,
    input  wire logic [ROW_CNT_W-1:0] ROW_TOTAL,
    input  wire logic                 IMAGE_SELECT,
    input  wire logic                 CAMERA_HOLD,
    input  wire logic [PIXEL_W-1:0]   VIDEO_SAMPLE,
    output logic                      HORIZONTAL_RUN_N,
    output logic                      STORAGE_RUN_N,
    output logic                      IMAGE_RUN_N,
    output logic                      CAMERA_RESET_N,
    output logic                      VERTICAL_BUSY,
    output logic                      MASTER_TICK,
    output logic [PIXEL_W-1:0]        PIXEL_DATA,
    output logic                      PIXEL_VALID
);
    logic [DIV_W-1:0]     div;
    logic                 tick;
    logic [DIV_W-1:0]     next_div;
    logic                 next_tick;

    vstate_t              vstate;
    vstate_t              next_vstate;
    logic [PHASE_W-1:0]   phase;
    logic [PHASE_W-1:0]   next_phase;
    logic [ROW_CNT_W-1:0] rows_left;
    logic [ROW_CNT_W-1:0] next_rows_left;
    logic                 pending;
    logic                 next_pending;
    logic [ROW_CNT_W-1:0] req_rows;
    logic [ROW_CNT_W-1:0] next_req_rows;
    logic                 req_image;
    logic                 next_req_image;
    logic                 image_on;
    logic                 next_image_on;

    logic                 horizontal_run_n;
    logic                 storage_run_n;
    logic                 image_run_n;
    logic                 camera_reset_n;
    logic                 busy;
    logic                 next_horizontal_run_n;
    logic                 next_storage_run_n;
    logic                 next_image_run_n;
    logic                 next_camera_reset_n;
    logic                 next_busy;

    pixel_if px ();

    // Idle decode shared by request capture and acceptance
    function automatic logic is_idle(input vstate_t state);
        logic idle;
        idle = (state == V_IDLE);
        return idle;
    endfunction : is_idle

    // Running decode shared by the run controls and the busy flag
    function automatic logic is_running(input vstate_t state);
        logic running;
        running = (state == V_RUN);
        return running;
    endfunction : is_running

    always_comb begin
        next_div  = (div == DIV_LAST) ? DIV_RESET : DIV_W'(div + 1'b1);
        next_tick = (div == DIV_LAST);
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            div  <= DIV_RESET;
            tick <= 1'b0;
        end else begin
            div  <= next_div;
            tick <= next_tick;
        end
    end

    // Row request capture and vertical sequencing
    always_comb begin
        next_vstate    = vstate;
        next_phase     = phase;
        next_rows_left = rows_left;
        next_req_rows  = req_rows;
        next_req_image = req_image;
        next_image_on  = image_on;
        next_pending   = pending;
        if (tick && is_idle(vstate) && pending) begin
            next_pending = 1'b0;
        end
        if (ROW_START && is_idle(vstate) && !pending && ROW_TOTAL != ROWS_RESET) begin
            next_pending   = 1'b1;
            next_req_rows  = ROW_TOTAL;
            next_req_image = IMAGE_SELECT;
        end
        if (tick) begin
            case (vstate)
                V_IDLE: begin
                    if (pending) begin
                        next_vstate    = V_RUN;
                        next_phase     = PHASE_RESET;
                        next_rows_left = req_rows;
                        next_image_on  = req_image;
                    end
                end
                V_RUN: begin
                    if (phase == PHASE_LAST) begin
                        next_phase = PHASE_RESET;
                        if (rows_left == ROW_ONE) begin
                            next_vstate    = V_IDLE;
                            next_rows_left = ROWS_RESET;
                            next_image_on  = 1'b0;
                        end else begin
                            next_rows_left = ROW_CNT_W'(rows_left - ROW_ONE);
                        end
                    end else begin
                        next_phase = PHASE_W'(phase + 1'b1);
                    end
                end
                default: begin
                    next_vstate = V_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            vstate    <= V_IDLE;
            phase     <= PHASE_RESET;
            rows_left <= ROWS_RESET;
            pending   <= 1'b0;
            req_rows  <= ROWS_RESET;
            req_image <= 1'b0;
            image_on  <= 1'b0;
        end else begin
            vstate    <= next_vstate;
            phase     <= next_phase;
            rows_left <= next_rows_left;
            pending   <= next_pending;
            req_rows  <= next_req_rows;
            req_image <= next_req_image;
            image_on  <= next_image_on;
        end
    end

    always_comb begin
        next_horizontal_run_n = horizontal_run_n;
        next_storage_run_n    = storage_run_n;
        next_image_run_n      = image_run_n;
        next_camera_reset_n   = camera_reset_n;
        // Busy follows the vertical state
        next_busy             = is_running(next_vstate);
        if (tick) begin
            next_horizontal_run_n = !HORIZONTAL_ENABLE;
            next_storage_run_n    = !is_running(next_vstate);
            next_image_run_n      = !(is_running(next_vstate) && next_image_on);
            next_camera_reset_n   = !CAMERA_HOLD;
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            horizontal_run_n <= RUN_IDLE;
            storage_run_n    <= RUN_IDLE;
            image_run_n      <= RUN_IDLE;
            camera_reset_n   <= 1'b0;
            busy             <= 1'b0;
        end else begin
            horizontal_run_n <= next_horizontal_run_n;
            storage_run_n    <= next_storage_run_n;
            image_run_n      <= next_image_run_n;
            camera_reset_n   <= next_camera_reset_n;
            busy             <= next_busy;
        end
    end

    assign px.tick = tick;

    pixel_capture u_capture (
        .clk       (CLK),
        .reset_n   (RESET_N),
        .video_pin (VIDEO_SAMPLE),
        .px        (px.capture)
    );

    assign HORIZONTAL_RUN_N = horizontal_run_n;
    assign STORAGE_RUN_N    = storage_run_n;
    assign IMAGE_RUN_N      = image_run_n;
    assign CAMERA_RESET_N   = camera_reset_n;
    assign VERTICAL_BUSY    = busy;
    assign MASTER_TICK      = tick;
    assign PIXEL_DATA       = px.data;
    assign PIXEL_VALID      = px.valid;

endmodule : ccd_head_sequencer_interface

// *** logic/pixel_capture.sv ***
`timescale 1ns/10ps
module pixel_capture
    import ccd_head_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               reset_n,
    input  wire logic [PIXEL_W-1:0] video_pin,
    pixel_if.capture                px
);
    logic [PIXEL_W-1:0] sync_a;
    logic [PIXEL_W-1:0] sync_b;
    logic [PIXEL_W-1:0] sample;
    logic               valid;
    logic [PIXEL_W-1:0] next_sample;
    logic               next_valid;

    always_comb begin
        next_sample = sample;
        next_valid  = px.tick;
        if (px.tick) begin
            next_sample = sync_b;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sync_a <= PIXEL_RESET;
            sync_b <= PIXEL_RESET;
            sample <= PIXEL_RESET;
            valid  <= 1'b0;
        end else begin
            sync_a <= video_pin;
            sync_b <= sync_a;
            sample <= next_sample;
            valid  <= next_valid;
        end
    end

    assign px.data  = sample;
    assign px.valid = valid;

endmodule : pixel_capture

// *** logic/pixel_if.sv ***
`timescale 1ns/10ps
interface pixel_if;
    import ccd_head_pkg::*;
    logic               tick;
    logic [PIXEL_W-1:0] data;
    logic               valid;
    modport capture (input tick, output data, output valid);
    modport consume (output tick, input data, input valid);
endinterface : pixel_if

// *** tb/ccd_head_model.sv ***
`timescale 1ns/10ps
module ccd_head_model
    import ccd_head_pkg::*;
(
    input wire logic              clk,
    input wire logic              rst_n,
    input wire logic              tick,
    input wire logic              horizontal_run_n,
    input wire logic              storage_run_n,
    input wire logic              image_run_n,
    output logic [PIXEL_W-1:0]    video,
    output int                    rows,
    output int                    img_rows
);
    logic [PIXEL_W-1:0] pix;
    logic [2:0]         phase;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pix      <= 9'h000;
            phase    <= 3'h0;
            rows     <= 0;
            img_rows <= 0;
        end else if (tick) begin
            // one pixel per tick, junk in standby
            pix   <= horizontal_run_n ? ~pix : pix + 9'h001;
            phase <= (storage_run_n || phase == 3'h5) ? 3'h0 : phase + 3'h1;
            if (!storage_run_n && phase == 3'h5) begin
                rows     <= rows + 1;
                img_rows <= image_run_n ? img_rows : img_rows + 1;
            end
        end
    end
    // word changes shortly after the edge
    assign #2 video = pix;
endmodule : ccd_head_model

// *** tb/ccd_head_sequencer_interface_asserts.sv ***
`timescale 1ns/10ps
module ccd_head_sequencer_interface_chk
    import ccd_head_pkg::*;
(
    input wire logic                 CLK,
    input wire logic                 RESET_N,
    input wire logic                 HORIZONTAL_ENABLE,
    input wire logic                 ROW_START,
    input wire logic [ROW_CNT_W-1:0] ROW_TOTAL,
    input wire logic                 IMAGE_SELECT,
    input wire logic                 CAMERA_HOLD,
    input wire logic [PIXEL_W-1:0]   VIDEO_SAMPLE,
    input wire logic                 HORIZONTAL_RUN_N,
    input wire logic                 STORAGE_RUN_N,
    input wire logic                 IMAGE_RUN_N,
    input wire logic                 CAMERA_RESET_N,
    input wire logic                 VERTICAL_BUSY,
    input wire logic                 MASTER_TICK,
    input wire logic [PIXEL_W-1:0]   PIXEL_DATA,
    input wire logic                 PIXEL_VALID
);
    logic [15:0] low_cnt;
    logic [15:0] next_low_cnt;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    // Cycles spent with storage run active
    always_comb begin
        next_low_cnt = STORAGE_RUN_N ? 16'h0000 : low_cnt + 16'h0001;
    end
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            low_cnt <= 16'h0000;
        end else begin
            low_cnt <= next_low_cnt;
        end
    end
    chk_tick_rate:
        assert property (MASTER_TICK |=> !MASTER_TICK [*3] ##1 MASTER_TICK) else $error("tick spacing wrong");
    chk_run_on_tick:
        assert property (($changed(HORIZONTAL_RUN_N) || $changed(STORAGE_RUN_N) || $changed(IMAGE_RUN_N) ||
                          $changed(CAMERA_RESET_N)) |-> $past(MASTER_TICK))
        else $error("run control moved off tick");
    chk_horiz_follow:
        assert property (MASTER_TICK |=> HORIZONTAL_RUN_N == !$past(HORIZONTAL_ENABLE)) else $error("horizontal run");
    chk_cam_follow:
        assert property (MASTER_TICK |=> CAMERA_RESET_N == !$past(CAMERA_HOLD)) else $error("camera reset level");
    chk_image_pair:
        assert property (!IMAGE_RUN_N |-> !STORAGE_RUN_N) else $error("image run without storage run");
    chk_row_multiple:
        assert property ($rose(STORAGE_RUN_N) |-> low_cnt != 16'h0000 && low_cnt % 24 == 0)
        else $error("storage pulse not whole rows");
    chk_busy_storage:
        assert property (1'b1 |-> VERTICAL_BUSY != STORAGE_RUN_N) else $error("busy and storage run differ");
    chk_pixel_strobe:
        assert property (1'b1 |=> PIXEL_VALID == $past(MASTER_TICK)) else $error("pixel strobe not after tick");
    chk_pixel_word:
        assert property (PIXEL_VALID |-> PIXEL_DATA == $past(VIDEO_SAMPLE, 3)) else $error("pixel word wrong");
endmodule : ccd_head_sequencer_interface_chk

bind ccd_head_sequencer_interface ccd_head_sequencer_interface_chk u_chk (
    .CLK(CLK), .RESET_N(RESET_N), .HORIZONTAL_ENABLE(HORIZONTAL_ENABLE), .ROW_START(ROW_START),
    .ROW_TOTAL(ROW_TOTAL), .IMAGE_SELECT(IMAGE_SELECT), .CAMERA_HOLD(CAMERA_HOLD), .VIDEO_SAMPLE(VIDEO_SAMPLE),
    .HORIZONTAL_RUN_N(HORIZONTAL_RUN_N), .STORAGE_RUN_N(STORAGE_RUN_N), .IMAGE_RUN_N(IMAGE_RUN_N),
    .CAMERA_RESET_N(CAMERA_RESET_N), .VERTICAL_BUSY(VERTICAL_BUSY), .MASTER_TICK(MASTER_TICK),
    .PIXEL_DATA(PIXEL_DATA), .PIXEL_VALID(PIXEL_VALID)
);

// *** tb/ccd_head_sequencer_interface_tb.sv ***
`timescale 1ns/10ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin err_count++; $display("ERROR %0t: got %h expected %h", $time, got, exp); end end
module ccd_head_sequencer_interface_tb;
    import ccd_head_pkg::*;
    logic                 CLK = 1'b0;
    logic                 RESET_N = 1'b0;
    logic                 HORIZONTAL_ENABLE = 1'b0;
    logic                 ROW_START = 1'b0;
    logic [ROW_CNT_W-1:0] ROW_TOTAL = 9'h000;
    logic                 IMAGE_SELECT = 1'b0;
    logic                 CAMERA_HOLD = 1'b0;
    logic [PIXEL_W-1:0]   VIDEO_SAMPLE;
    logic                 HORIZONTAL_RUN_N, STORAGE_RUN_N, IMAGE_RUN_N, CAMERA_RESET_N;
    logic                 VERTICAL_BUSY, MASTER_TICK, PIXEL_VALID;
    logic [PIXEL_W-1:0]   PIXEL_DATA;
    int                   rows, img_rows, err_count = 0, checks_done = 0, cycles = 0;
    ccd_head_sequencer_interface uut (.CLK(CLK), .RESET_N(RESET_N), .HORIZONTAL_ENABLE(HORIZONTAL_ENABLE),
        .ROW_START(ROW_START), .ROW_TOTAL(ROW_TOTAL), .IMAGE_SELECT(IMAGE_SELECT), .CAMERA_HOLD(CAMERA_HOLD),
        .VIDEO_SAMPLE(VIDEO_SAMPLE), .HORIZONTAL_RUN_N(HORIZONTAL_RUN_N), .STORAGE_RUN_N(STORAGE_RUN_N),
        .IMAGE_RUN_N(IMAGE_RUN_N), .CAMERA_RESET_N(CAMERA_RESET_N), .VERTICAL_BUSY(VERTICAL_BUSY),
        .MASTER_TICK(MASTER_TICK), .PIXEL_DATA(PIXEL_DATA), .PIXEL_VALID(PIXEL_VALID));
    ccd_head_model head (.clk(CLK), .rst_n(RESET_N), .tick(MASTER_TICK), .horizontal_run_n(HORIZONTAL_RUN_N),
        .storage_run_n(STORAGE_RUN_N), .image_run_n(IMAGE_RUN_N), .video(VIDEO_SAMPLE), .rows(rows),
        .img_rows(img_rows));
    always #12.5 CLK = ~CLK;
    always @(posedge CLK) begin
        cycles++;
        if (cycles == 2000) begin
            err_count++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : stop_test
    task automatic cyc(input int n);
        repeat (n) @(posedge CLK);
        #2;
    endtask : cyc
    task automatic wait_valid();
        int n = 0;
        while (PIXEL_VALID !== 1'b1 && n < 8) begin
            cyc(1);
            n++;
        end
        `CHK(PIXEL_VALID, 1'b1)
    endtask : wait_valid
    task automatic t_reset();
        cyc(16);
        `CHK(CAMERA_RESET_N, 1'b0)
        `CHK(STORAGE_RUN_N, 1'b1)
        RESET_N = 1'b1;
        cyc(8);
        `CHK(CAMERA_RESET_N, 1'b1)
        $display("reset test done");
    endtask : t_reset
    task automatic t_horizontal();
        logic [PIXEL_W-1:0] first;
        HORIZONTAL_ENABLE = 1'b1;
        cyc(12);
        `CHK(HORIZONTAL_RUN_N, 1'b0)
        wait_valid();
        first = PIXEL_DATA;
        cyc(1);
        wait_valid();
        `CHK(PIXEL_DATA, first + 9'h001)
        HORIZONTAL_ENABLE = 1'b0;
        cyc(8);
        `CHK(HORIZONTAL_RUN_N, 1'b1)
        $display("horizontal test done");
    endtask : t_horizontal
    task automatic t_camera();
        CAMERA_HOLD = 1'b1;
        cyc(6);
        `CHK(CAMERA_RESET_N, 1'b0)
        CAMERA_HOLD = 1'b0;
        cyc(6);
        `CHK(CAMERA_RESET_N, 1'b1)
        $display("camera test done");
    endtask : t_camera
    task automatic pulse(input logic [ROW_CNT_W-1:0] total);
        ROW_TOTAL = total;
        ROW_START = 1'b1;
        cyc(1);
        ROW_START = 1'b0;
    endtask : pulse
    task automatic t_rows(input logic img);
        int n = 0;
        int r0 = rows;
        int i0 = img_rows;
        pulse(9'h000);
        cyc(8);
        `CHK(VERTICAL_BUSY, 1'b0)
        IMAGE_SELECT = img;
        pulse(9'h002);
        while (STORAGE_RUN_N !== 1'b0 && n < 8) begin
            cyc(1);
            n++;
        end
        `CHK(IMAGE_RUN_N, !img)
        pulse(9'h005);
        n = 1;
        while (STORAGE_RUN_N === 1'b0 && n < 200) begin
            cyc(1);
            n++;
        end
        `CHK(n, 48)
        `CHK(IMAGE_RUN_N, 1'b1)
        cyc(8);
        `CHK(VERTICAL_BUSY, 1'b0)
        `CHK(rows - r0, 2)
        `CHK(img_rows - i0, img ? 2 : 0)
        $display("row test done");
    endtask : t_rows
    initial begin
        t_reset();
        t_horizontal();
        t_camera();
        t_rows(1'b0);
        t_rows(1'b1);
        stop_test();
    end
endmodule : ccd_head_sequencer_interface_tb
